// File: logic/sideband_pkg.sv
package sideband_pkg;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;     // ref_clk rate
  localparam int unsigned RESET_PULSE_NS = 10000;   // least reset pin low time
  localparam int unsigned INIT_NS        = 2000000; // reset initialisation interval
  // least time rounds up
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  // longest time rounds down
  localparam int unsigned INIT_CYC        = (INIT_NS * CLK_MHZ) / 1000;
  // ---------------------------------------------
  // register map
  // ---------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_MOD_STATUS = 8'h00; // bit0 data not ready
  localparam logic [7:0] OFS_FLAGS      = 8'h04; // latched flags, clear on read
  localparam logic [7:0] OFS_POWER_CTRL = 8'h08; // override, set, high class
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C; // sticky events
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h10; // write one to clear
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14; // event enables
  localparam logic [7:0] OFS_PIN_STATUS = 8'h18; // synced pins, raw interrupt pin and state
  // ---------------------------------------------
  // fields and reset values
  // ---------------------------------------------
  localparam int unsigned DNR_BIT      = 0;
  localparam int unsigned PWR_OVR_BIT  = 0;
  localparam int unsigned PWR_SET_BIT  = 1;
  localparam int unsigned PWR_HPCE_BIT = 2;
  localparam int unsigned IRQ_DONE_BIT = 0; // reset completed
  localparam int unsigned IRQ_FLT_BIT  = 1; // fault flag latched
  localparam int unsigned IRQ_RST_BIT  = 2; // reset pulse accepted
  localparam int unsigned IRQ_W        = 3;
  localparam logic [2:0] POWER_CTRL_RST = 3'h0;
  localparam logic [2:0] IRQ_EN_RST     = 3'h0;
  // ---------------------------------------------
  // states
  // ---------------------------------------------
  typedef enum logic [1:0] {
    stHold,  // reset pin held low after a valid pulse
    stInit,  // initialisation interval running
    stReady  // normal operation
  } state_t;
endpackage : sideband_pkg

// File: logic/module_sideband_control.sv
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module module_sideband_control
  import sideband_pkg::*;
#(
  parameter int unsigned FLAG_W   = 8,        // width of the fault flag field
  parameter int unsigned INIT_CYC_P = INIT_CYC  // shorten for simulation
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              moduleSelectN,
  input  wire logic              moduleResetN,
  input  wire logic              lowPowerRequest,
  input  wire logic [FLAG_W-1:0] faultFlags,
  input  wire logic              interruptNIn,
  output logic                   interruptNOut,
  output logic                   interruptNOe,
  output logic                   modulePresentN,
  output logic                   busRespondEn,
  output logic                   lowPowerMode,
  output logic                   highPowerEn,
  output logic                   irqOut,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWe,
  input  wire logic              regRe,
  output logic [31:0]            regRdata
);

  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic selS1, selS2;   // select pin stages
  logic rstS1, rstS2;   // reset pin stages
  logic lpS1, lpS2;     // low-power pin stages

  // pins float high in the module, so reset to the idle level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {selS1, selS2} <= 2'h3;
      {rstS1, rstS2} <= 2'h3;
      {lpS1, lpS2}   <= 2'h3;
    end else begin
      selS1 <= moduleSelectN;
      selS2 <= selS1;
      rstS1 <= moduleResetN;
      rstS2 <= rstS1;
      lpS1  <= lowPowerRequest;
      lpS2  <= lpS1;
    end
  end

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  state_t            state_q;      // sequence state
  logic [11:0]       lowCnt_q;     // reset pin low time
  logic              pulseOk_q;    // low pulse long enough
  logic [31:0]       initCnt_q;    // initialisation timer
  logic              dnr_q;        // data not ready
  logic              intPending_q; // interrupt owed to host
  logic              dnrSeen_q;    // not-ready read as zero
  logic              flagSeen_q;   // flag field read
  logic [FLAG_W-1:0] flags_q;      // latched faults
  logic [2:0]        pwrCtrl_q;    // software power bits
  logic [IRQ_W-1:0]  irqStat_q;    // sticky events
  logic [IRQ_W-1:0]  irqEn_q;      // event enables
  logic              doneEvt;      // initialisation finished
  logic              fltEvt;       // new fault flag seen
  logic              rdStatus;     // status byte read
  logic              rdFlags;      // flag field read
  logic              userRst;      // valid pulse qualified

  assign doneEvt  = (state_q == stInit) && (initCnt_q == 32'(INIT_CYC_P - 1));
  assign fltEvt   = (state_q == stReady) && |(faultFlags & ~flags_q);
  assign rdStatus = regRe && (regAddr == OFS_MOD_STATUS);
  assign rdFlags  = regRe && (regAddr == OFS_FLAGS);
  assign userRst  = !pulseOk_q && !rstS2 && (lowCnt_q == 12'(RESET_PULSE_CYC));

  // ---------------------------------------------
  // reset pulse qualification
  // ---------------------------------------------
  // a glitch shorter than the least pulse is ignored outright
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt_q  <= 12'h000;
      pulseOk_q <= 1'b0;
    end else if (rstS2) begin
      lowCnt_q  <= 12'h000;
      pulseOk_q <= 1'b0;
    end else begin
      if (lowCnt_q != 12'(RESET_PULSE_CYC)) begin
        lowCnt_q <= lowCnt_q + 12'h001;
      end
      if (userRst) begin
        pulseOk_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  // power-up enters initialisation with no pulse needed
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= stInit;
      initCnt_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        stHold: begin
          if (rstS2) begin
            state_q   <= stInit;
            initCnt_q <= 32'h0000_0000;
          end
        end
        stInit: begin
          initCnt_q <= initCnt_q + 32'h0000_0001;
          if (doneEvt) begin
            state_q <= stReady;
          end
        end
        default: begin
          initCnt_q <= 32'h0000_0000;
        end
      endcase
      // a valid pulse aborts whatever was running
      if (userRst) begin
        state_q <= stHold;
      end
    end
  end

  // ---------------------------------------------
  // not-ready bit and interrupt handshake
  // ---------------------------------------------
  // status is meaningless to the host until completion
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dnr_q <= 1'b1;
    end else if (userRst) begin
      dnr_q <= 1'b1;
    end else if (doneEvt) begin
      dnr_q <= 1'b0;
    end
  end

  // a new event wins over the release, and restarts the reads
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      intPending_q <= 1'b0;
      dnrSeen_q    <= 1'b0;
      flagSeen_q   <= 1'b0;
    end else if (userRst) begin
      intPending_q <= 1'b0;
      dnrSeen_q    <= 1'b0;
      flagSeen_q   <= 1'b0;
    end else if (doneEvt || fltEvt) begin
      intPending_q <= 1'b1;
      dnrSeen_q    <= 1'b0;
      flagSeen_q   <= 1'b0;
    end else if (intPending_q && dnrSeen_q && flagSeen_q) begin
      intPending_q <= 1'b0;
      dnrSeen_q    <= 1'b0;
      flagSeen_q   <= 1'b0;
    end else begin
      if (rdStatus && !dnr_q) begin
        dnrSeen_q <= 1'b1;
      end
      if (rdFlags) begin
        flagSeen_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // fault flags, clear on read
  // ---------------------------------------------
  // new faults in the read cycle survive the clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= '0;
    end else if (userRst) begin
      flags_q <= '0;
    end else if (rdFlags) begin
      flags_q <= (state_q == stReady) ? faultFlags : '0;
    end else if (state_q == stReady) begin
      flags_q <= flags_q | faultFlags;
    end
  end

  // ---------------------------------------------
  // software power bits and enables
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwrCtrl_q <= POWER_CTRL_RST;
      irqEn_q   <= IRQ_EN_RST;
    end else if (userRst) begin
      pwrCtrl_q <= POWER_CTRL_RST;
      irqEn_q   <= IRQ_EN_RST;
    end else if (regWe) begin
      if (regAddr == OFS_POWER_CTRL) begin
        pwrCtrl_q <= regWdata[2:0];
      end else if (regAddr == OFS_IRQ_ENABLE) begin
        irqEn_q <= regWdata[IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------
  // sticky event status
  // ---------------------------------------------
  logic [IRQ_W-1:0] irqSet; // this cycle's events
  assign irqSet = {userRst, fltEvt, doneEvt};

  // set beats clear when both land together
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_q <= '0;
    end else if (regWe && (regAddr == OFS_IRQ_CLEAR)) begin
      irqStat_q <= (irqStat_q & ~regWdata[IRQ_W-1:0]) | irqSet;
    end else begin
      irqStat_q <= irqStat_q | irqSet;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  // the host's own settle times around select are not checked here
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busRespondEn   <= 1'b0;
      lowPowerMode   <= 1'b1;
      highPowerEn    <= 1'b0;
      modulePresentN <= 1'b0;
      interruptNOut  <= 1'b0;
      interruptNOe   <= 1'b1;
      irqOut         <= 1'b0;
    end else begin
      busRespondEn   <= !selS2;
      // override hands the choice to software, else the pin rules
      lowPowerMode   <= pwrCtrl_q[PWR_OVR_BIT] ? pwrCtrl_q[PWR_SET_BIT] : lpS2;
      highPowerEn    <= pwrCtrl_q[PWR_HPCE_BIT] &&
                        !(pwrCtrl_q[PWR_OVR_BIT] ? pwrCtrl_q[PWR_SET_BIT] : lpS2);
      modulePresentN <= 1'b0;
      interruptNOut  <= 1'b0;
      interruptNOe   <= !intPending_q;
      irqOut         <= |(irqStat_q & irqEn_q);
    end
  end

  // ---------------------------------------------
  // register read port
  // ---------------------------------------------
  // unmapped and write-only offsets read as zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h0000_0000;
    end else if (!regRe) begin
      regRdata <= 32'h0000_0000;
    end else if (regAddr == OFS_MOD_STATUS) begin
      regRdata <= {31'h0000_0000, dnr_q};
    end else if (regAddr == OFS_FLAGS) begin
      regRdata <= 32'(flags_q);
    end else if (regAddr == OFS_POWER_CTRL) begin
      regRdata <= {29'h0000_0000, pwrCtrl_q};
    end else if (regAddr == OFS_IRQ_STATUS) begin
      regRdata <= 32'(irqStat_q);
    end else if (regAddr == OFS_IRQ_ENABLE) begin
      regRdata <= 32'(irqEn_q);
    end else if (regAddr == OFS_PIN_STATUS) begin
      regRdata <= {26'h000_0000, state_q, interruptNIn, lpS2, rstS2, selS2};
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sel_open_a: assert property (!selS2 |=> busRespondEn)
    else $error("selected module not answering");
  sel_gate_a: assert property (selS2 |=> !busRespondEn)
    else $error("deselected module still answering");
  pulse_reset_a: assert property (userRst |=> pwrCtrl_q == POWER_CTRL_RST && dnr_q)
    else $error("valid pulse did not restore defaults");
  init_start_a: assert property (state_q == stHold && rstS2 |=> state_q == stInit ##1 initCnt_q == 32'h1)
    else $error("initialisation not started at release");
  done_int_a: assert property (doneEvt |=> !dnr_q && intPending_q ##1 !interruptNOe)
    else $error("completion not reported");
  init_dnr_a: assert property (state_q != stReady |-> dnr_q)
    else $error("not ready cleared early");
  lp_pin_a: assert property (!pwrCtrl_q[PWR_OVR_BIT] && lpS2 |=> lowPowerMode)
    else $error("low-power pin ignored");
  pwr_ovr_a: assert property (pwrCtrl_q[PWR_OVR_BIT] |=> lowPowerMode == $past(pwrCtrl_q[PWR_SET_BIT]))
    else $error("power override ignored");
  present_low_a: assert property (!modulePresentN)
    else $error("presence not driven low");
  int_drive_a: assert property (intPending_q |=> !interruptNOe)
    else $error("pending interrupt not driven");
  int_release_a: assert property (intPending_q && dnrSeen_q && flagSeen_q && !doneEvt && !fltEvt && !userRst
                                  |=> !intPending_q ##1 interruptNOe)
    else $error("interrupt not released after reads");
  open_drain_a: assert property (!interruptNOut)
    else $error("interrupt pin driven high");
  sel_sync_a: assert property (selS2 == $past(moduleSelectN, 2))
    else $error("select not two-stage synchronised");

  powerup_c: cover property (doneEvt ##[1:20] !intPending_q);
  pinreset_c: cover property (userRst ##[1:100] state_q == stInit);
  fault_c: cover property (fltEvt ##1 irqOut);
  lowpower_c: cover property ($rose(lowPowerMode));

endmodule : module_sideband_control

// File: verification/host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter int SEL_WAIT = 6  // select settle cycles, plain default
) (
  input  wire logic ref_clk,
  output logic      moduleSelectN,
  output logic      moduleResetN,
  output logic      lowPowerRequest,
  input  wire logic interruptNOut,
  input  wire logic interruptNOe,
  output logic      interruptNIn
);
  // ---------------------------------------------
  // interrupt wire
  // ---------------------------------------------
  // host pull-up wins unless the module pulls low
  assign interruptNIn = interruptNOe ? 1'b1 : interruptNOut;
  // pins idle high, as their pull-ups leave them
  initial begin
    moduleSelectN   = 1'b1;
    moduleResetN    = 1'b1;
    lowPowerRequest = 1'b1;
  end
  // ---------------------------------------------
  // pin tasks
  // ---------------------------------------------
  // select change, then quiet bus until the settle time has run
  task automatic set_select(input logic n);
    @(posedge ref_clk);
    moduleSelectN <= n;
    repeat (SEL_WAIT) @(posedge ref_clk);
  endtask : set_select
  // low-power pin level
  task automatic set_low_power(input logic lp);
    @(posedge ref_clk);
    lowPowerRequest <= lp;
  endtask : set_low_power
  // reset pulse of a given length in cycles
  task automatic pulse_reset(input int cycles);
    @(posedge ref_clk);
    moduleResetN <= 1'b0;
    repeat (cycles) @(posedge ref_clk);
    moduleResetN <= 1'b1;
  endtask : pulse_reset
endmodule : host_model

// File: verification/module_sideband_control_tb.sv
`timescale 1ns/1ps
module module_sideband_control_tb
  import sideband_pkg::*;
;
  localparam int INIT_SIM = 50;  // shortened initialisation
  logic        ref_clk, resetn, moduleSelectN, moduleResetN, lowPowerRequest;
  logic [7:0]  faultFlags, regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic        regWe, regRe, interruptNIn, interruptNOut, interruptNOe;
  logic        modulePresentN, busRespondEn, lowPowerMode, highPowerEn, irqOut;
  int          badCount, checkCount;
  // ---------------------------------------------
  // clock, reset, instances
  // ---------------------------------------------
  always #2 ref_clk = ~ref_clk;
  module_sideband_control #(.FLAG_W(8), .INIT_CYC_P(INIT_SIM)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .moduleSelectN(moduleSelectN), .moduleResetN(moduleResetN), .lowPowerRequest(lowPowerRequest),
    .faultFlags(faultFlags), .interruptNIn(interruptNIn), .interruptNOut(interruptNOut),
    .interruptNOe(interruptNOe), .modulePresentN(modulePresentN), .busRespondEn(busRespondEn),
    .lowPowerMode(lowPowerMode), .highPowerEn(highPowerEn), .irqOut(irqOut), .regAddr(regAddr),
    .regWdata(regWdata), .regWe(regWe), .regRe(regRe), .regRdata(regRdata));
  host_model host (.ref_clk(ref_clk), .moduleSelectN(moduleSelectN), .moduleResetN(moduleResetN),
    .lowPowerRequest(lowPowerRequest), .interruptNOut(interruptNOut), .interruptNOe(interruptNOe),
    .interruptNIn(interruptNIn));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= v;
    regWe    <= 1'b1;
    @(posedge ref_clk);
    regWe <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRe   <= 1'b1;
    @(posedge ref_clk);
    regRe <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // status is ignored while waiting; completion must land in its window
  task automatic wait_int(input int lo, input int hi);
    int n;
    n = 0;
    while (interruptNIn !== 1'b0 && n <= hi) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, n >= lo && n <= hi}, 32'h1);
    rd(OFS_MOD_STATUS);
    check({31'h0, d[DNR_BIT]}, 32'h0);
  endtask : wait_int
  // source found over the bus, then the wire lets go
  task automatic release_int(input logic [31:0] flags);
    rd(OFS_FLAGS);
    check(d, flags);
    rd(OFS_MOD_STATUS);
    repeat (3) @(posedge ref_clk);
    #1 check({31'h0, interruptNIn}, 32'h1);
  endtask : release_int
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic test_power_up;
    wait_int(INIT_SIM - 2, INIT_SIM + 10);
    check({31'h0, modulePresentN}, 32'h0);
    rd(OFS_MOD_STATUS);
    repeat (4) @(posedge ref_clk);
    // status reads alone must not release the wire
    #1 check({31'h0, interruptNIn}, 32'h0);
    release_int(32'h0);
    $display("test power_up done");
  endtask : test_power_up
  task automatic test_select;
    host.set_select(1'b0);
    check({31'h0, busRespondEn}, 32'h1);
    // synced pins, raw interrupt pin and state as software sees them
    rd(OFS_PIN_STATUS);
    check(d, {26'h0, stReady, 4'hE});
    host.set_select(1'b1);
    check({31'h0, busRespondEn}, 32'h0);
    $display("test select done");
  endtask : test_select
  task automatic test_power;
    repeat (5) @(posedge ref_clk);
    check({31'h0, lowPowerMode}, 32'h1);
    host.set_low_power(1'b0);
    repeat (5) @(posedge ref_clk);
    check({31'h0, lowPowerMode}, 32'h0);
    wr(OFS_POWER_CTRL, 32'h3);
    repeat (3) @(posedge ref_clk);
    check({31'h0, lowPowerMode}, 32'h1);
    check({31'h0, highPowerEn}, 32'h0);
    host.set_low_power(1'b1);
    // override to full power with the high class allowed
    wr(OFS_POWER_CTRL, 32'h5);
    repeat (5) @(posedge ref_clk);
    check({31'h0, lowPowerMode}, 32'h0);
    check({31'h0, highPowerEn}, 32'h1);
    rd(OFS_POWER_CTRL);
    check(d, 32'h5);
    // unmapped place and write-only clear read as zero
    rd(8'h1C);
    check(d, 32'h0);
    rd(OFS_IRQ_CLEAR);
    check(d, 32'h0);
    $display("test power done");
  endtask : test_power
  task automatic test_fault;
    @(posedge ref_clk);
    faultFlags <= 8'h81;
    repeat (4) @(posedge ref_clk);
    faultFlags <= 8'h00;
    #1 check({31'h0, interruptNIn}, 32'h0);
    rd(OFS_IRQ_STATUS);
    check({31'h0, d[IRQ_FLT_BIT]}, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h2);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irqOut}, 32'h1);
    // masked, then enabled and cleared
    wr(OFS_IRQ_ENABLE, 32'h0);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irqOut}, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h2);
    wr(OFS_IRQ_CLEAR, 32'h2);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irqOut}, 32'h0);
    release_int(32'h81);
    // clear on read leaves nothing behind
    rd(OFS_FLAGS);
    check(d, 32'h0);
    $display("test fault done");
  endtask : test_fault
  task automatic test_pin_reset;
    host.pulse_reset(RESET_PULSE_CYC + 10);
    wait_int(INIT_SIM, INIT_SIM + 12);
    rd(OFS_POWER_CTRL);
    check(d, {29'h0, POWER_CTRL_RST});
    check({31'h0, lowPowerMode}, 32'h1);
    check({31'h0, highPowerEn}, 32'h0);
    rd(OFS_IRQ_STATUS);
    // done and pin-reset events logged, fault cleared earlier
    check(d, 32'h5);
    $display("test pin_reset done");
  endtask : test_pin_reset
  // ---------------------------------------------
  // verdict
  // ---------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    ref_clk    = 1'b0;
    resetn     = 1'b0;
    faultFlags = 8'h00;
    regAddr    = 8'h00;
    regWdata   = 32'h0;
    regWe      = 1'b0;
    regRe      = 1'b0;
    badCount   = 0;
    checkCount = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    test_power_up();
    test_select();
    test_power();
    test_fault();
    test_pin_reset();
    final_report();
  end
  // watchdog, far beyond the few thousand cycles expected
  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    final_report();
  end
endmodule : module_sideband_control_tb
